// file: hdl/aod_map.vh
`ifndef AOD_MAP_VH
`define AOD_MAP_VH

// sample and threshold geometry
`define AOD_SMP_W        12
`define AOD_MAG_W        11
`define AOD_THR_W        8
`define AOD_THR_LSB      3
`define AOD_MOST_NEG     12'h800
`define AOD_MAG_SAT      11'h7ff

// flag pulse length: base shifted left by the 3-bit select
`define AOD_PULSE_BASE   11'h008
`define AOD_PULSE_W      11
`define AOD_SEL_W        3

// embedded monitoring window, counted in samples
`define AOD_WIN_W        9
`define AOD_WIN_ONE      9'h001

// output format codes
`define AOD_FMT_W        5
`define AOD_FMT_REAL     5'h09
`define AOD_FMT_CPLX_LO  5'h0a
`define AOD_FMT_CPLX_HI  5'h10
`define AOD_FMT_CPLX_NOT 5'h0c

// output word and buffer
`define AOD_DEC_W        16
`define AOD_FIFO_W       32
`define AOD_FIFO_D       32
`define AOD_FIFO_AW      5
`define AOD_FIFO_SLACK   6'h1d

`endif

// file: hdl/aod_fifo.v
// the output buffer module sits in aod_overrange.v beside its only user

// file: hdl/aod_overrange.v
// How it works
// - samples arrive as signed twos complement, -2048 to +2047
// - dual mode one sample per clock; single mode rise and fall lanes
// - magnitude of each sample, upper 8 bits compared to two thresholds
// - both channels share the same two threshold settings
// - magnitude of -2048 saturates to 2047, upper bits read 255
// - flag is 1 when upper magnitude bits reach threshold, else 0
// - two flag outputs per channel, index 0 first, index 1 second
// - flag held 8 shifted by 3-bit select cycles after last event
// - only decimating formats embed overrange status into samples
// - complex: I carries first status LSB, Q carries second status LSB
// - real: even samples carry first status, odd carry second status
// - embedded bit set if channel reached threshold within the window
// - window 2^(sel+1) samples real format 9, 2^sel complex 10-16 not 12
// - foreground calibration stops sampling; background keeps converting
`timescale 1ns/1ps
`include "aod_map.vh"
module aod_overrange
(
   input  wire        sys_clk,             // 200 MHz device clock
   input  wire        rst_n,               // sync reset, active low
   input  wire        single_chan_mode,    // 1 = single-channel mode
   input  wire        fg_cal_busy,         // foreground calibration active
   input  wire [7:0]  first_limit_level,   // first threshold
   input  wire [7:0]  second_limit_level,  // second threshold
   input  wire [2:0]  hold_period_select,  // pulse and window select
   input  wire [4:0]  link_format_select,  // output format code
   input  wire        smp_valid,           // core samples present
   input  wire [11:0] smp_a,               // core a sample (rise lane)
   input  wire [11:0] smp_b,               // core b sample (fall lane)
   input  wire        dec_valid,           // decimated word pair present
   output reg         dec_ready_ff,        // room for decimated words
   input  wire        dec_is_q,            // word pair is a Q sample
   input  wire [15:0] dec_a,               // channel a output word
   input  wire [15:0] dec_b,               // channel b output word
   output reg         chan_a_flag_first,   // channel a, first threshold
   output reg         chan_a_flag_second,  // channel a, second threshold
   output reg         chan_b_flag_first,   // channel b, first threshold
   output reg         chan_b_flag_second,  // channel b, second threshold
   output wire        out_valid,           // output word pair present
   input  wire        out_ready,           // downstream takes word pair
   output wire [31:0] out_data             // {channel a, channel b}
);

   // format decode
   wire fmt_real;
   wire fmt_cplx;
   wire fmt_embed;

   assign fmt_real  = (link_format_select == `AOD_FMT_REAL);
   assign fmt_cplx  = (link_format_select >= `AOD_FMT_CPLX_LO) &&
                      (link_format_select <= `AOD_FMT_CPLX_HI) &&
                      (link_format_select != `AOD_FMT_CPLX_NOT);
   assign fmt_embed = fmt_real || fmt_cplx;

   // sample capture
   // in single mode lane a holds the rising-edge sample and lane b
   // the falling-edge sample, so two samples land per clock
   reg                     smp_v_ff;
   reg  [`AOD_SMP_W-1:0]   smp_a_ff;
   reg  [`AOD_SMP_W-1:0]   smp_b_ff;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         smp_v_ff <= 1'b0;
         smp_a_ff <= 12'h000;
         smp_b_ff <= 12'h000;
      end
      else
      begin
         // foreground calibration takes the cores offline
         smp_v_ff <= smp_valid && !fg_cal_busy;
         smp_a_ff <= smp_a;
         smp_b_ff <= smp_b;
      end
   end

   // magnitude and compare, one generate entry per lane/threshold
   // entry bit 1 = lane (0 a, 1 b), bit 0 = threshold (0 first)
   reg  [3:0]             hit_ff;
   reg                    hit_v_ff;
   wire [3:0]             nxt_hit;
   wire [3:0]             nxt_flag;
   wire [3:0]             emb_st;
   wire [`AOD_WIN_W-1:0]  win_len;
   reg  [`AOD_WIN_W-1:0]  win_cnt_ff;
   wire                   win_end;
   wire [`AOD_PULSE_W-1:0] pulse_len;

   // the complex window is half the real one for the same select
   assign win_len = fmt_real ?
                    (`AOD_WIN_ONE << ({1'b0, hold_period_select} + 4'h1)) :
                    (`AOD_WIN_ONE << hold_period_select);
   // at or past the end, so a shorter window after a select change closes
   assign win_end = (win_cnt_ff >= win_len - `AOD_WIN_ONE);
   assign pulse_len = `AOD_PULSE_BASE << hold_period_select;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_chk
         wire [`AOD_SMP_W-1:0] s;
         wire [`AOD_SMP_W-1:0] neg;
         wire [`AOD_MAG_W-1:0] mag;
         wire [`AOD_THR_W-1:0] upper;
         wire [`AOD_THR_W-1:0] thr;
         reg  [`AOD_PULSE_W-1:0] cnt_ff;
         reg                   acc_ff;
         reg                   emb_bit_ff;

         assign s   = (gi >= 2) ? smp_b_ff : smp_a_ff;
         assign neg = (~s) + 12'h001;
         // most negative code has no positive twin: saturate
         assign mag = (s == `AOD_MOST_NEG) ? `AOD_MAG_SAT :
                      (s[`AOD_SMP_W-1] ? neg[`AOD_MAG_W-1:0] :
                       s[`AOD_MAG_W-1:0]);
         assign upper = mag[`AOD_MAG_W-1:`AOD_THR_LSB];
         // one pair of limits serves both lanes
         assign thr = (gi % 2 == 1) ? second_limit_level :
                                      first_limit_level;
         assign nxt_hit[gi] = smp_v_ff && (upper >= thr);

         // pulse counter reloads on every hit
         always @(posedge sys_clk)
         begin
            if (!rst_n)
               cnt_ff <= 11'h000;
            else if (hit_ff[gi])
               cnt_ff <= pulse_len - 11'h001;
            else if (cnt_ff != 11'h000)
               cnt_ff <= cnt_ff - 11'h001;
         end
         assign nxt_flag[gi] = hit_ff[gi] ||
                               (cnt_ff != 11'h000);
         assign emb_st[gi]   = emb_bit_ff;

         // window accumulator; a hit in the closing cycle is kept
         always @(posedge sys_clk)
         begin
            if (!rst_n)
            begin
               acc_ff     <= 1'b0;
               emb_bit_ff <= 1'b0;
            end
            else if (hit_v_ff)
            begin
               if (win_end)
               begin
                  emb_bit_ff <= acc_ff || hit_ff[gi];
                  acc_ff     <= 1'b0;
               end
               else
                  acc_ff <= acc_ff || hit_ff[gi];
            end
         end
      end
   endgenerate

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         hit_ff   <= 4'h0;
         hit_v_ff <= 1'b0;
      end
      else
      begin
         hit_ff   <= nxt_hit;
         hit_v_ff <= smp_v_ff;
      end
   end

   // samples counted once for both lanes; resets on format change
   reg [`AOD_FMT_W-1:0] fmt_last_ff;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         win_cnt_ff  <= 9'h000;
         fmt_last_ff <= 5'h00;
      end
      else
      begin
         fmt_last_ff <= link_format_select;
         if (fmt_last_ff != link_format_select)
            win_cnt_ff <= 9'h000;
         else if (hit_v_ff)
            win_cnt_ff <= win_end ? 9'h000 :
                          (win_cnt_ff + `AOD_WIN_ONE);
      end
   end

   // flag pins; single mode needs the monitor to OR lanes a and b
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         chan_a_flag_first  <= 1'b0;
         chan_a_flag_second <= 1'b0;
         chan_b_flag_first  <= 1'b0;
         chan_b_flag_second <= 1'b0;
      end
      else
      begin
         chan_a_flag_first  <= nxt_flag[0];
         chan_a_flag_second <= nxt_flag[1];
         chan_b_flag_first  <= nxt_flag[2];
         chan_b_flag_second <= nxt_flag[3];
      end
   end

   // output words, optional status embedding
   reg                    odd_ff;
   reg                    stg_v_ff;
   reg  [`AOD_FIFO_W-1:0] stg_d_ff;
   wire                   sel_second;
   wire                   bit_a;
   wire                   bit_b;
   wire [`AOD_DEC_W-1:0]  word_a;
   wire [`AOD_DEC_W-1:0]  word_b;
   wire                   take;
   wire                   fifo_in_ready;
   wire [`AOD_FIFO_AW:0]  fifo_level;

   assign take = dec_valid && dec_ready_ff;
   // complex picks by I/Q, real by sample parity
   assign sel_second = fmt_cplx ? dec_is_q : odd_ff;
   assign bit_a = sel_second ? emb_st[1] : emb_st[0];
   assign bit_b = sel_second ? emb_st[3] : emb_st[2];
   assign word_a = fmt_embed ? {dec_a[`AOD_DEC_W-1:1], bit_a} :
                               dec_a;
   assign word_b = fmt_embed ? {dec_b[`AOD_DEC_W-1:1], bit_b} :
                               dec_b;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
         odd_ff <= 1'b0;
      else if (!fmt_real)
         odd_ff <= 1'b0;
      else if (take)
         odd_ff <= ~odd_ff;
   end

   // ready is registered, so it lags the buffer by a cycle; the
   // slack keeps the staging word from ever being stuck
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         dec_ready_ff <= 1'b0;
         stg_v_ff     <= 1'b0;
         stg_d_ff     <= 32'h0000_0000;
      end
      else
      begin
         dec_ready_ff <= (fifo_level < `AOD_FIFO_SLACK);
         if (take)
         begin
            stg_v_ff <= 1'b1;
            stg_d_ff <= {word_a, word_b};
         end
         else if (fifo_in_ready)
            stg_v_ff <= 1'b0;
      end
   end

   aod_fifo
   #(
      .W  (`AOD_FIFO_W),
      .D  (`AOD_FIFO_D),
      .AW (`AOD_FIFO_AW)
   )
   u_fifo
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (stg_v_ff),
      .in_ready  (fifo_in_ready),
      .in_data   (stg_d_ff),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data),
      .level     (fifo_level)
   );

endmodule

module aod_fifo
#(
   parameter W  = 32,
   parameter D  = 32,
   parameter AW = 5
)
(
   input  wire          sys_clk,    // clock
   input  wire          rst_n,      // sync reset
   input  wire          in_valid,   // write request
   output wire          in_ready,   // room in store
   input  wire [W-1:0]  in_data,    // write word
   output reg           out_valid,  // head word present
   input  wire          out_ready,  // consumer takes head
   output reg  [W-1:0]  out_data,   // head word
   output wire [AW:0]   level       // words in store
);
   localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
   localparam [AW:0]   CNT_ONE = {{AW{1'b0}}, 1'b1};
   reg  [W-1:0] mem [0:D-1];
   reg  [AW-1:0] wr_ptr_ff;
   reg  [AW-1:0] rd_ptr_ff;
   reg  [AW:0]   cnt_ff;
   wire          push;
   wire          pop;

   assign in_ready = (cnt_ff != D[AW:0]);
   assign push     = in_valid && in_ready;
   // head register refills whenever it is empty or being taken
   assign pop      = (cnt_ff != {(AW+1){1'b0}}) && (!out_valid || out_ready);
   assign level    = cnt_ff;

   always @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         cnt_ff    <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {W{1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
         if (pop)
         begin
            rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
            out_data  <= mem[rd_ptr_ff];
            out_valid <= 1'b1;
         end
         else if (out_ready)
            out_valid <= 1'b0;
         if (push && !pop)
            cnt_ff <= cnt_ff + CNT_ONE;
         else if (pop && !push)
            cnt_ff <= cnt_ff - CNT_ONE;
      end
   end
endmodule

// file: test/aod_overrange_assertions.sv
`timescale 1ns/1ps
module aod_overrange_assertions
(
   input logic        sys_clk,             // clock
   input logic        rst_n,               // sync reset
   input logic        fg_cal_busy,         // cal active
   input logic [7:0]  first_limit_level,   // threshold 0
   input logic [7:0]  second_limit_level,  // threshold 1
   input logic [2:0]  hold_period_select,  // pulse select
   input logic        smp_valid,           // sample strobe
   input logic [11:0] smp_a,               // lane a
   input logic [11:0] smp_b,               // lane b
   input logic        chan_a_flag_first,   // flag
   input logic        chan_a_flag_second,  // flag
   input logic        chan_b_flag_first,   // flag
   input logic        chan_b_flag_second,  // flag
   input logic        out_valid,           // word present
   input logic        out_ready,           // word taken
   input logic [31:0] out_data             // word pair
);
   function automatic logic [7:0] up8(input logic [11:0] s);
      logic [11:0] m;
      m = s[11] ? -s : s;
      return (s == 12'h800) ? 8'hff : m[10:3];
   endfunction
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire        tk  = smp_valid && !fg_cal_busy;
   wire        ha1 = tk && (up8(smp_a) >= first_limit_level);
   wire        ha2 = tk && (up8(smp_a) >= second_limit_level);
   wire        hb1 = tk && (up8(smp_b) >= first_limit_level);
   wire        hb2 = tk && (up8(smp_b) >= second_limit_level);
   wire [10:0] len = 11'h008 << hold_period_select;
   logic [10:0] age_ff;
   wire [10:0] nxt_age = ha1 ? 11'h000 :
                         (age_ff == 11'h7ff) ? age_ff : age_ff + 11'h001;
   always @(posedge sys_clk)
      if (!rst_n)
         age_ff <= 11'h7ff;
      else
         age_ff <= nxt_age;
   a_one_hit_a:
      assert property (ha1 |-> ##4 chan_a_flag_first)
      else $error("chan a first flag missed");
   a_two_hit_a:
      assert property (ha2 |-> ##4 chan_a_flag_second)
      else $error("chan a second flag missed");
   b_one_hit_a:
      assert property (hb1 |-> ##4 chan_b_flag_first)
      else $error("chan b first flag missed");
   b_two_hit_a:
      assert property (hb2 |-> ##4 chan_b_flag_second)
      else $error("chan b second flag missed");
   pulse_len_a:
      assert property (chan_a_flag_first == ($past(nxt_age, 3) < len))
      else $error("flag pulse length wrong");
   b_one_cause_a:
      assert property ($rose(chan_b_flag_first) |-> $past(hb1, 3))
      else $error("chan b first flag without hit");
   b_two_cause_a:
      assert property ($rose(chan_b_flag_second) |-> $past(hb2, 3))
      else $error("chan b second flag without hit");
   out_hold_a:
      assert property (out_valid && !out_ready |=>
                       out_valid && $stable(out_data))
      else $error("output word not held");
endmodule
bind aod_overrange aod_overrange_assertions chk_u (.sys_clk, .rst_n,
   .fg_cal_busy, .first_limit_level, .second_limit_level,
   .hold_period_select, .smp_valid, .smp_a, .smp_b, .chan_a_flag_first,
   .chan_a_flag_second, .chan_b_flag_first, .chan_b_flag_second,
   .out_valid, .out_ready, .out_data);

// file: test/aod_sink.sv
`timescale 1ns/1ps
module aod_sink
(
   input  logic        sys_clk,            // clock
   input  logic        out_valid,          // word present
   input  logic [31:0] out_data,           // word pair
   output logic        out_ready,          // take word
   input  logic        hold_off,           // stall all
   input  logic        slow,               // every other cycle
   input  logic        chan_a_flag_first,  // lane a flag
   input  logic        chan_b_flag_first,  // lane b flag
   output logic        any_first           // merged flag
);
   logic [31:0] got[$];
   logic        tog_ff = 1'b0;
   initial out_ready = 1'b0;
   always @(negedge sys_clk)
   begin
      tog_ff <= !tog_ff;
      out_ready <= !hold_off && !(slow && tog_ff);
   end
   always @(posedge sys_clk)
      if (out_valid && out_ready)
         got.push_back(out_data);
   assign any_first = chan_a_flag_first | chan_b_flag_first;
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        sys_clk = 1'b0, rst_n = 1'b0, fg_cal_busy = 1'b0;
   logic        single_chan_mode = 1'b0, smp_valid = 1'b0;
   logic [7:0]  first_limit_level = 8'h00, second_limit_level = 8'h00;
   logic [2:0]  hold_period_select = 3'h0;
   logic [4:0]  link_format_select = 5'h00;
   logic [11:0] smp_a = 12'h000, smp_b = 12'h000;
   logic        dec_valid = 1'b0, dec_is_q = 1'b0;
   logic [15:0] dec_a = 16'h0000, dec_b = 16'h0000;
   logic        hold_off = 1'b0, slow = 1'b0;
   wire         dec_ready_ff, out_valid, out_ready, any_first;
   wire         chan_a_flag_first, chan_a_flag_second;
   wire         chan_b_flag_first, chan_b_flag_second;
   wire  [31:0] out_data;
   int          bad_count = 0, total_checks = 0, cyc = 0;
   always #2.5 sys_clk = !sys_clk;
   aod_overrange dut_u (.sys_clk, .rst_n, .single_chan_mode, .fg_cal_busy,
      .first_limit_level, .second_limit_level, .hold_period_select,
      .link_format_select, .smp_valid, .smp_a, .smp_b, .dec_valid,
      .dec_ready_ff, .dec_is_q, .dec_a, .dec_b, .chan_a_flag_first,
      .chan_a_flag_second, .chan_b_flag_first, .chan_b_flag_second,
      .out_valid, .out_ready, .out_data);
   aod_sink sink_u (.sys_clk, .out_valid, .out_data, .out_ready, .hold_off,
      .slow, .chan_a_flag_first, .chan_b_flag_first, .any_first);
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic push(input logic [15:0] a, b, input logic q);
      int t;
      dec_valid = 1'b1;
      dec_a = a;
      dec_b = b;
      dec_is_q = q;
      t = 0;
      while (dec_ready_ff !== 1'b1 && t < 200)
      begin
         @(negedge sys_clk);
         t++;
      end
      chk(t < 200, "push stuck");
      @(negedge sys_clk);
   endtask
   task automatic wait_got(input int n);
      int t;
      t = 0;
      while (sink_u.got.size() < n && t < 500)
      begin
         @(negedge sys_clk);
         t++;
      end
      chk(sink_u.got.size() == n, "word count");
   endtask
   task automatic t_mag;
      logic [11:0] s[5] = '{12'h7ff, 12'h800, 12'h810, 12'h7f0, 12'h000};
      logic [7:0]  u[5] = '{8'hff, 8'hff, 8'hfe, 8'hfe, 8'h00};
      first_limit_level = 8'hff;
      second_limit_level = 8'hfe;
      for (int i = 0; i < 5; i++)
      begin
         smp_valid = 1'b1;
         smp_a = s[i];
         smp_b = s[4-i];
         @(negedge sys_clk);
         smp_valid = 1'b0;
         @(negedge sys_clk);
         chk(chan_a_flag_first === 1'b0, "flag early");
         @(negedge sys_clk);
         chk(chan_a_flag_first === (u[i] >= 8'hff), "a first");
         chk(chan_a_flag_second === (u[i] >= 8'hfe), "a second");
         chk(chan_b_flag_first === (u[4-i] >= 8'hff), "b first");
         chk(chan_b_flag_second === (u[4-i] >= 8'hfe), "b second");
         repeat (12) @(negedge sys_clk);
      end
      $display("t_mag done");
   endtask
   task automatic t_pulse;
      int na, nb;
      na = 0;
      nb = 0;
      single_chan_mode = 1'b1;
      first_limit_level = 8'he4;
      second_limit_level = 8'h40;
      hold_period_select = 3'h2;
      smp_a = 12'h7ff;
      smp_b = 12'h000;
      for (int k = 0; k < 80; k++)
      begin
         smp_valid = (k == 0 || k == 10 || k == 60);
         fg_cal_busy = (k == 60);
         @(negedge sys_clk);
         na += (any_first === 1'b1);
         nb += (chan_b_flag_second === 1'b1);
      end
      smp_valid = 1'b0;
      fg_cal_busy = 1'b0;
      single_chan_mode = 1'b0;
      chk(na == 42, "pulse length");
      chk(nb == 0, "lane b quiet");
      $display("t_pulse done");
   endtask
   task automatic t_fifo;
      int n, base;
      link_format_select = 5'h05;
      hold_off = 1'b1;
      base = sink_u.got.size();
      n = 0;
      while (dec_ready_ff === 1'b1 && n < 40)
      begin
         push(16'(n), ~16'(n), 1'b0);
         n++;
      end
      dec_valid = 1'b0;
      chk(n >= 29 && n <= 32, "fill depth");
      hold_off = 1'b0;
      wait_got(base + n);
      for (int k = 0; k < n; k++)
         chk(sink_u.got[base+k] === {16'(k), ~16'(k)}, "fifo order");
      $display("t_fifo done");
   endtask
   task automatic t_embed(input logic [4:0] fmt, input logic emb, rl);
      int base;
      logic [15:0] v;
      logic e;
      link_format_select = fmt;
      first_limit_level = 8'h32;
      second_limit_level = 8'hc8;
      hold_period_select = 3'h1;
      smp_a = 12'h320;
      smp_b = 12'hce0;
      smp_valid = 1'b1;
      slow = 1'b1;
      repeat (20) @(negedge sys_clk);
      base = sink_u.got.size();
      for (int k = 0; k < 4; k++)
         push(16'h1230 + 16'(k), ~(16'h1230 + 16'(k)), k[1]);
      dec_valid = 1'b0;
      wait_got(base + 4);
      for (int k = 0; k < 4; k++)
      begin
         e = rl ? k[0] : k[1];
         v = 16'h1230 + 16'(k);
         chk(sink_u.got[base+k] === (emb ? {v[15:1], !e, ~v[15:1], !e} :
             {v, ~v}), "embedded word");
      end
      smp_valid = 1'b0;
      slow = 1'b0;
      repeat (20) @(negedge sys_clk);
      $display("t_embed done");
   endtask
   initial
   begin
      repeat (16) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      t_mag;
      t_pulse;
      t_fifo;
      t_embed(5'h0a, 1'b1, 1'b0);
      t_embed(5'h10, 1'b1, 1'b0);
      t_embed(5'h09, 1'b1, 1'b1);
      t_embed(5'h0c, 1'b0, 1'b0);
      t_embed(5'h05, 1'b0, 1'b0);
      summarize;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         summarize;
      end
   end
endmodule
